// ===== rtl/pll_cfg_pkg.sv
/*
 * Constants for the PLL configuration word decoder: register map,
 * field positions, reset values and derived figures.
 * Assumes a plain strobe register port with byte addresses.
 */
package pll_cfg_pkg;

	// Register port
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CFG_WORD = 4'h0;
	localparam logic [3:0] OFS_PROG_WORD = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	// Field positions in the configuration word
	localparam int ODIV_LSB = 16;
	localparam int USB_BYPASS_BIT = 15;
	localparam int UDIV_LSB = 8;
	localparam int MUL_LSB = 4;
	localparam int CODE_W = 3;

	// Reserved positions must hold ones: 31..19, 14..11, 7, 3
	localparam logic [31:0] RSVD_MASK = 32'hfff8_7888;

	// Erased nonvolatile word reads all ones
	localparam logic [31:0] CFG_RESET = 32'hffff_ffff;

	// Control register bits
	localparam int CTRL_APPLY_BIT = 0;
	localparam int CTRL_CLR_ERR_BIT = 1;

	// Status register fields
	localparam int ST_MUL_LSB = 0;
	localparam int ST_ODIV_LSB = 8;
	localparam int ST_UDIV_LSB = 20;
	localparam int ST_BYPASS_BIT = 24;
	localparam int ST_USB_PRES_BIT = 25;
	localparam int ST_RSVD_ERR_BIT = 26;
	localparam int ST_LOADED_BIT = 27;

	// Decoded value widths
	localparam int MUL_W = 5;
	localparam int ODIV_W = 9;
	localparam int SHIFT_W = 4;
	localparam int UDIV_W = 4;

	// Default PLL input frequency in kHz
	localparam logic [15:0] PLL_IN_KHZ_DEF = 16'd4000;

	typedef enum logic {
		ST_CAPTURE,
		ST_RUN
	} cap_state_t;

endpackage

// ===== rtl/pll_code_decode.sv
/*
 * Turns the three-bit codes of the configuration word into
 * multiplier, output divisor and USB input divider values.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/10ps
`default_nettype none

module pll_code_decode (
	// Codes
	input wire logic [pll_cfg_pkg::CODE_W-1:0] mul_code_i,
	input wire logic [pll_cfg_pkg::CODE_W-1:0] odiv_code_i,
	input wire logic [pll_cfg_pkg::CODE_W-1:0] udiv_code_i,
	// Decoded values
	output logic [pll_cfg_pkg::MUL_W-1:0] mult_o,
	output logic [pll_cfg_pkg::ODIV_W-1:0] odiv_o,
	output logic [pll_cfg_pkg::SHIFT_W-1:0] odiv_shift_o,
	output logic [pll_cfg_pkg::UDIV_W-1:0] udiv_o
);
	import pll_cfg_pkg::*;

	always_comb begin
		case (mul_code_i)
			3'h7: mult_o = 5'd24;
			default: mult_o = MUL_W'(5'd15 + {2'h0, mul_code_i});
		endcase
	end

	always_comb begin
		case (odiv_code_i)
			3'h7: odiv_shift_o = 4'h8;
			default: odiv_shift_o = {1'b0, odiv_code_i};
		endcase
		odiv_o = ODIV_W'(9'h001 << odiv_shift_o);
	end

	always_comb begin
		case (udiv_code_i)
			3'h6: udiv_o = 4'ha;
			3'h7: udiv_o = 4'hc;
			default: udiv_o = UDIV_W'({1'b0, udiv_code_i} + 4'h1);
		endcase
	end

endmodule

`default_nettype wire

// ===== rtl/pll_config_word_decode.sv
/*
 * PLL configuration word decoder: captures the nonvolatile
 * configuration word after reset, decodes it and drives the
 * clock generator settings and the resulting system clock figure.
 * Assumes the nonvolatile word is stable while reset is released
 * and that registers are reached over a plain strobe port.
 */
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Output divisor codes 0..7 divide PLL output by 1,2,4,8,16,32,64,256.
// - USB PLL control bit clear enables USB PLL; set disables and bypasses.
// - USB input divider codes 0..7 divide by 1,2,3,4,5,6,10,12.
// - Multiplier codes 0..7 select 15,16,17,18,19,20,21,24.
// - USB fields only act on variants with USB; elsewhere ignored.
module pll_config_word_decode #(
	parameter logic USB_PRESENT = 1'b1,
	parameter logic [15:0] PLL_IN_KHZ = pll_cfg_pkg::PLL_IN_KHZ_DEF
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Nonvolatile configuration source
	input wire logic [31:0] nv_word_i,
	// Register port
	input wire logic [pll_cfg_pkg::ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Clock generator settings
	output logic [pll_cfg_pkg::MUL_W-1:0] pll_multiplier_o,
	output logic [pll_cfg_pkg::ODIV_W-1:0] pll_output_divisor_o,
	output logic [pll_cfg_pkg::UDIV_W-1:0] usb_pll_input_divider_o,
	output logic usb_pll_bypass_o,
	output logic [31:0] sys_clk_khz_o,
	output logic cfg_loaded_o
);
	import pll_cfg_pkg::*;

	cap_state_t state;
	logic [31:0] pll_config_word;
	logic [31:0] prog_word;
	logic rsvd_err;

	logic [31:0] next_word;
	logic wr_cfg;
	logic wr_prog;
	logic wr_ctrl;
	logic apply;
	logic prog_bad;
	logic cfg_bad;
	logic [MUL_W-1:0] next_mult;
	logic [ODIV_W-1:0] next_odiv;
	logic [SHIFT_W-1:0] next_shift;
	logic [UDIV_W-1:0] dec_udiv;
	logic [UDIV_W-1:0] next_udiv;
	logic next_bypass;
	logic [31:0] next_khz;
	logic [31:0] next_rdata;

	////////////////////////////////////////////////////////////////
	// Register decode

	always_comb begin
		wr_cfg = wr_i && (addr_i == OFS_CFG_WORD);
		wr_prog = wr_i && (addr_i == OFS_PROG_WORD);
		wr_ctrl = wr_i && (addr_i == OFS_CTRL);
		apply = wr_ctrl && wdata_i[CTRL_APPLY_BIT];
	end

	// Reserved positions not all ones in a programmed word or in the captured word
	always_comb begin
		prog_bad = wr_prog && ((wdata_i & RSVD_MASK) != RSVD_MASK);
		cfg_bad = (state == ST_CAPTURE) && ((nv_word_i & RSVD_MASK) != RSVD_MASK);
	end

	////////////////////////////////////////////////////////////////
	// Capture of the active configuration word

	always_comb begin
		case (state)
			ST_CAPTURE: next_word = nv_word_i;
			ST_RUN: next_word = apply ? prog_word : pll_config_word;
			default: next_word = pll_config_word;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_CAPTURE;
		end else begin
			case (state)
				ST_CAPTURE: state <= ST_RUN;
				ST_RUN: state <= ST_RUN;
				default: state <= ST_CAPTURE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_config_word <= CFG_RESET;
		end else begin
			pll_config_word <= next_word;
		end
	end

	// Writing the active word directly is refused; after capture only apply loads it
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prog_word <= CFG_RESET;
		end else if (wr_prog) begin
			prog_word <= wdata_i;
		end
	end

	// Sticky reserved-bit violation, set wins over clear
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsvd_err <= 1'b0;
		end else if (prog_bad || cfg_bad) begin
			rsvd_err <= 1'b1;
		end else if (wr_ctrl && wdata_i[CTRL_CLR_ERR_BIT]) begin
			rsvd_err <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Field decode

	pll_code_decode u_decode (
		.mul_code_i(next_word[MUL_LSB +: CODE_W]),
		.odiv_code_i(next_word[ODIV_LSB +: CODE_W]),
		.udiv_code_i(next_word[UDIV_LSB +: CODE_W]),
		.mult_o(next_mult),
		.odiv_o(next_odiv),
		.odiv_shift_o(next_shift),
		.udiv_o(dec_udiv)
	);

	// Variants without USB keep the USB PLL bypassed at divide by one
	always_comb begin
		if (USB_PRESENT) begin
			next_bypass = next_word[USB_BYPASS_BIT];
			next_udiv = dec_udiv;
		end else begin
			next_bypass = 1'b1;
			next_udiv = 4'h1;
		end
	end

	// Every divisor is a power of two, so divide by shifting
	always_comb begin
		next_khz = 32'(({16'h0000, PLL_IN_KHZ} * {27'h0, next_mult}) >> next_shift);
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_multiplier_o <= 5'd24;
			pll_output_divisor_o <= 9'h100;
		end else begin
			pll_multiplier_o <= next_mult;
			pll_output_divisor_o <= next_odiv;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			usb_pll_input_divider_o <= 4'h1;
			usb_pll_bypass_o <= 1'b1;
		end else begin
			usb_pll_input_divider_o <= next_udiv;
			usb_pll_bypass_o <= next_bypass;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sys_clk_khz_o <= 32'h0000_0000;
		end else begin
			sys_clk_khz_o <= next_khz;
		end
	end

	assign cfg_loaded_o = (state == ST_RUN);

	////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				OFS_CFG_WORD: next_rdata = pll_config_word;
				OFS_PROG_WORD: next_rdata = prog_word;
				OFS_STATUS: begin
					next_rdata[ST_MUL_LSB +: MUL_W] = pll_multiplier_o;
					next_rdata[ST_ODIV_LSB +: ODIV_W] = pll_output_divisor_o;
					next_rdata[ST_UDIV_LSB +: UDIV_W] = usb_pll_input_divider_o;
					next_rdata[ST_BYPASS_BIT] = usb_pll_bypass_o;
					next_rdata[ST_USB_PRES_BIT] = USB_PRESENT;
					next_rdata[ST_RSVD_ERR_BIT] = rsvd_err;
					next_rdata[ST_LOADED_BIT] = cfg_loaded_o;
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_odiv_table: assert property (
		cfg_loaded_o |-> pll_output_divisor_o ==
		((pll_config_word[ODIV_LSB +: CODE_W] == 3'h7) ? 9'h100 :
		ODIV_W'(9'h001 << pll_config_word[ODIV_LSB +: CODE_W])))
		else $error("output divisor does not match its code");

	a_usb_bypass_bit: assert property (
		(cfg_loaded_o && USB_PRESENT) |->
		usb_pll_bypass_o == pll_config_word[USB_BYPASS_BIT])
		else $error("usb pll bypass does not follow its bit");

	a_udiv_table: assert property (
		(cfg_loaded_o && USB_PRESENT) |-> usb_pll_input_divider_o ==
		((pll_config_word[UDIV_LSB +: CODE_W] == 3'h7) ? 4'hc :
		(pll_config_word[UDIV_LSB +: CODE_W] == 3'h6) ? 4'ha :
		UDIV_W'({1'b0, pll_config_word[UDIV_LSB +: CODE_W]} + 4'h1)))
		else $error("usb input divider does not match its code");

	a_mult_table: assert property (
		cfg_loaded_o |-> pll_multiplier_o ==
		((pll_config_word[MUL_LSB +: CODE_W] == 3'h7) ? 5'd24 :
		MUL_W'(5'd15 + {2'h0, pll_config_word[MUL_LSB +: CODE_W]})))
		else $error("multiplier does not match its code");

	a_rsvd_flag: assert property (
		prog_bad |=> rsvd_err)
		else $error("reserved bit violation not flagged");

	a_no_usb_fields: assert property (
		!USB_PRESENT |-> (usb_pll_bypass_o && usb_pll_input_divider_o == 4'h1))
		else $error("usb fields act on a variant without usb");

	a_capture_word: assert property (
		(state == ST_CAPTURE) |=> (pll_config_word == $past(nv_word_i)) &&
		cfg_loaded_o)
		else $error("configuration word not captured after reset");

	a_sys_clk_value: assert property (
		cfg_loaded_o |-> sys_clk_khz_o ==
		32'({16'h0000, PLL_IN_KHZ} * {27'h0, pll_multiplier_o} /
		{23'h0, pll_output_divisor_o}))
		else $error("system clock figure wrong");

	a_word_holds: assert property (
		(cfg_loaded_o && !apply) |=> $stable(pll_config_word))
		else $error("active word changed without apply");

	a_cfg_write_refused: assert property (
		(cfg_loaded_o && wr_cfg) |=> $stable(pll_config_word))
		else $error("direct write reached the active word");

	a_outputs_hold: assert property (
		(cfg_loaded_o && !apply) |=> $stable(pll_multiplier_o) &&
		$stable(pll_output_divisor_o) && $stable(sys_clk_khz_o) &&
		$stable(usb_pll_bypass_o))
		else $error("clock settings changed without apply");

	a_capture_flag: assert property (
		cfg_bad |=> rsvd_err)
		else $error("captured reserved bit violation not flagged");

	a_rsvd_clear: assert property (
		(wr_ctrl && wdata_i[CTRL_CLR_ERR_BIT] && !prog_bad && !cfg_bad) |=> !rsvd_err)
		else $error("reserved bit error not cleared");

	a_loaded_stays: assert property (
		cfg_loaded_o |=> cfg_loaded_o)
		else $error("loaded flag dropped without reset");

	c_apply: cover property (cfg_loaded_o && apply ##1 cfg_loaded_o);
	c_div_256: cover property (pll_output_divisor_o == 9'h100 && cfg_loaded_o);
	c_usb_enabled: cover property (cfg_loaded_o && !usb_pll_bypass_o);
	c_rsvd_err: cover property (prog_bad ##1 rsvd_err);

endmodule

`default_nettype wire

// ===== verif/tb_pll_config_word_decode.sv
/*
 * Self-checking bench for the PLL configuration word decoder.
 * Assumes the package constants and a design with and without USB.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_pll_config_word_decode;
	import pll_cfg_pkg::*;

	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [31:0] nv_word_i = 32'h0;
	logic [ADDR_W-1:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] sys_clk_khz_o;
	logic [MUL_W-1:0] pll_multiplier_o;
	logic [ODIV_W-1:0] pll_output_divisor_o;
	logic [UDIV_W-1:0] usb_pll_input_divider_o;
	logic [UDIV_W-1:0] udiv2;
	logic usb_pll_bypass_o;
	logic byp2;
	logic cfg_loaded_o;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] seed = 32'hc72e;
	int mt[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
	int dt[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
	int ut[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
	logic [31:0] w;

	pll_config_word_decode uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.nv_word_i(nv_word_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .pll_multiplier_o(pll_multiplier_o),
		.pll_output_divisor_o(pll_output_divisor_o),
		.usb_pll_input_divider_o(usb_pll_input_divider_o),
		.usb_pll_bypass_o(usb_pll_bypass_o), .sys_clk_khz_o(sys_clk_khz_o),
		.cfg_loaded_o(cfg_loaded_o));

	// Variant without the USB function
	pll_config_word_decode #(.USB_PRESENT(1'b0)) uut2 (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .nv_word_i(nv_word_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(),
		.pll_multiplier_o(), .pll_output_divisor_o(),
		.usb_pll_input_divider_o(udiv2), .usb_pll_bypass_o(byp2),
		.sys_clk_khz_o(), .cfg_loaded_o());

	always #5 sys_clk_i = ~sys_clk_i;

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] status_of(input logic [31:0] a, input logic err);
		logic [31:0] s;
		s = 32'h0;
		s[4:0] = 5'(mt[a[6:4]]);
		s[16:8] = 9'(dt[a[18:16]]);
		s[23:20] = 4'(ut[a[10:8]]);
		s[24] = a[15];
		s[25] = 1'b1;
		s[26] = err;
		s[27] = 1'b1;
		return s;
	endfunction

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(exp, rdata_o);
	endtask

	// Outputs against the model of the active word
	task automatic check_all(input logic [31:0] a);
		int m;
		int d;
		m = mt[a[6:4]];
		d = dt[a[18:16]];
		chk(32'(m), 32'(pll_multiplier_o));
		chk(32'(d), 32'(pll_output_divisor_o));
		chk(32'(ut[a[10:8]]), 32'(usb_pll_input_divider_o));
		chk(32'(a[15]), 32'(usb_pll_bypass_o));
		chk(32'(int'(PLL_IN_KHZ_DEF) * m / d), sys_clk_khz_o);
		chk(32'h1, 32'(byp2));
		chk(32'h1, 32'(udiv2));
		chk(32'h1, 32'(cfg_loaded_o));
	endtask

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		@(posedge sys_clk_i);
		w = xs() | RSVD_MASK;
		nv_word_i <= w;
		repeat (11) @(posedge sys_clk_i);
		chk(32'h0, 32'(cfg_loaded_o));
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		check_all(w);
		rd(OFS_CFG_WORD, w);
		@(posedge sys_clk_i);
		#1;
		chk(32'h0, rdata_o);
		for (int k = 0; k < 24; k++) begin
			w = xs() | RSVD_MASK;
			if (k < 8) begin
				w[18:16] = 3'(k);
				w[10:8] = 3'(k);
				w[6:4] = 3'(k);
				w[15] = k[0];
			end
			wr(OFS_PROG_WORD, w);
			rd(OFS_PROG_WORD, w);
			wr(OFS_CTRL, 32'h1);
			check_all(w);
			rd(OFS_CFG_WORD, w);
			rd(OFS_STATUS, status_of(w, 1'b0));
		end
		wr(OFS_PROG_WORD, w & ~32'h8);
		rd(OFS_STATUS, status_of(w, 1'b1));
		wr(OFS_CTRL, 32'h2);
		rd(OFS_STATUS, status_of(w, 1'b0));
		wr(OFS_CFG_WORD, 32'h0);
		wr(OFS_STATUS, 32'h0);
		rd(OFS_CFG_WORD, w);
		rd(OFS_CTRL, 32'h0);
		rd(4'h2, 32'h0);
		check_all(w);
		@(posedge sys_clk_i);
		reset_n_i <= 1'b0;
		// Captured word breaks a reserved position to raise the error
		w = (xs() | RSVD_MASK) & ~32'h80;
		nv_word_i <= w;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(32'd24, 32'(pll_multiplier_o));
		chk(32'h100, 32'(pll_output_divisor_o));
		chk(32'h1, 32'(usb_pll_input_divider_o));
		chk(32'h1, 32'(usb_pll_bypass_o));
		chk(32'h0, sys_clk_khz_o);
		chk(32'h0, 32'(cfg_loaded_o));
		@(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		check_all(w);
		rd(OFS_STATUS, status_of(w, 1'b1));
		rd(OFS_PROG_WORD, CFG_RESET);
		finish_test();
	end
endmodule

`default_nettype wire
